// File: core/scm_channel.sv
// The Wishbone slave port was left to the implementer.
`timescale 1ns/100ps
module scm_channel (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [7:0]  wb_dat_i,
  output logic      [7:0]  wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic        wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  output logic             txd,
  input  wire logic        rxd,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe,
  output logic             irq
);
  import scm_pkg::*;

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic [7:0] frameMode;
  logic [7:0] bitRate;
  logic [7:0] chanCtrl;
  logic [7:0] txHold;
  logic       txHoldFull;
  logic [7:0] irqStatus;
  logic [7:0] irqMask;
  logic [7:0] rxData;
  logic [7:0] next_rdata;
  logic       busReq;
  logic       wrStb;
  logic       rdStb;
  logic       syncMode;
  logic       clock_source_sel_hi;
  logic       clock_source_sel_lo;

  assign busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrStb    = busReq & wb_we_i & wb_sel_i;
  assign rdStb    = busReq & ~wb_we_i;
  assign syncMode = frameMode[FM_SYNC];
  assign clock_source_sel_hi     = chanCtrl[CC_CKE_HI];
  assign clock_source_sel_lo     = chanCtrl[CC_CKE_LO];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busReq;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    unique case (wb_adr_i)
      ADDR_FRAME_MODE: next_rdata = frameMode;
      ADDR_BIT_RATE:   next_rdata = bitRate;
      IDX_CHAN_CTRL:   next_rdata = chanCtrl;
      IDX_TX_DATA:     next_rdata = txHold;
      IDX_IRQ_STATUS:  next_rdata = irqStatus;
      IDX_IRQ_MASK:    next_rdata = irqMask;
      IDX_RX_DATA:     next_rdata = rxData;
      default:         next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wb_dat_o <= 8'h00;
    end else if (rdStb) begin
      wb_dat_o <= next_rdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      frameMode <= RST_FRAME_MODE;
      bitRate   <= RST_BIT_RATE;
      chanCtrl  <= RST_CHAN_CTRL;
      irqMask   <= RST_MASK;
    end else if (wrStb) begin
      if (wb_adr_i == ADDR_FRAME_MODE) begin
        frameMode <= wb_dat_i;
      end
      if (wb_adr_i == ADDR_BIT_RATE) begin
        bitRate <= wb_dat_i;
      end
      if (wb_adr_i == IDX_CHAN_CTRL) begin
        chanCtrl <= wb_dat_i;
      end
      if (wb_adr_i == IDX_IRQ_MASK) begin
        irqMask <= wb_dat_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // Baud clock generation
  // ---------------------------------------------------------------
  logic [5:0] pscCount;
  logic [5:0] pscLimit;
  logic       pscTick;
  logic [7:0] brrCount;
  logic       sampleTick;
  logic [3:0] sampleCount;
  logic       intBitTick;
  logic       sckPrev;
  logic       extEdge;
  logic       extFall;
  logic       extRise;
  logic       asyncTick;
  logic       syncShift;
  logic       syncSample;
  logic       intClk;

  always_comb begin
    unique case (frameMode[FM_PSC_HI:FM_PSC_LO])
      2'b00: pscLimit = 6'h00;
      2'b01: pscLimit = PSC_DIV4;
      2'b10: pscLimit = PSC_DIV16;
      2'b11: pscLimit = PSC_DIV64;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pscCount <= 6'h00;
    end else if (pscCount >= pscLimit) begin
      pscCount <= 6'h00;
    end else begin
      pscCount <= pscCount + 6'h01;
    end
  end
  assign pscTick = (pscCount >= pscLimit);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      brrCount <= 8'h00;
    end else if (pscTick) begin
      if (brrCount >= bitRate) begin
        brrCount <= 8'h00;
      end else begin
        brrCount <= brrCount + 8'h01;
      end
    end
  end
  assign sampleTick = pscTick & (brrCount >= bitRate);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sampleCount <= 4'h0;
      intClk      <= 1'b1;
    end else if (sampleTick) begin
      sampleCount <= sampleCount + 4'h1;
      if (sampleCount == 4'h7 || sampleCount == 4'hf) begin
        intClk <= ~intClk;
      end
    end
  end
  assign intBitTick = sampleTick & (sampleCount == 4'hf);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sckPrev <= 1'b1;
    end else begin
      sckPrev <= sck_i;
    end
  end
  assign extFall = sckPrev & ~sck_i;
  assign extRise = ~sckPrev & sck_i;
  assign extEdge = extRise;

  assign asyncTick  = clock_source_sel_hi ? extEdge : sampleTick;
  assign syncShift  = clock_source_sel_hi ? extFall : (sampleTick & (sampleCount == 4'h7));
  assign syncSample = clock_source_sel_hi ? extRise : intBitTick;

  always_comb begin
    sck_oe = 1'b0;
    sck_o  = 1'b1;
    if (syncMode && !clock_source_sel_hi) begin
      sck_oe = 1'b1;
      sck_o  = intClk;
    end else if (!syncMode && !clock_source_sel_hi && clock_source_sel_lo) begin
      sck_oe = 1'b1;
      sck_o  = intClk;
    end
  end

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  scm_tx_t    txState;
  logic [7:0] txShift;
  logic [2:0] txBit;
  logic [3:0] txPhase;
  logic       txPar;
  logic       txStop;
  logic       txLoad;
  logic       txStep;
  logic [2:0] lastBit;
  logic       txDone;

  assign lastBit = frameMode[FM_CHR7] ? 3'h6 : 3'h7;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      txPhase <= 4'h0;
    end else if (txState == TX_IDLE) begin
      txPhase <= 4'h0;
    end else if (asyncTick) begin
      txPhase <= txPhase + 4'h1;
    end
  end
  assign txStep = syncMode ? syncShift : (asyncTick & (txPhase == 4'hf));
  assign txLoad = (txState == TX_IDLE) & txHoldFull & chanCtrl[CC_TXEN]
                & (syncMode ? syncShift : asyncTick);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      txHold     <= 8'h00;
      txHoldFull <= 1'b0;
    end else if (wrStb && wb_adr_i == IDX_TX_DATA) begin
      txHold     <= wb_dat_i;
      txHoldFull <= 1'b1;
    end else if (txLoad) begin
      txHoldFull <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      txState <= TX_IDLE;
      txShift <= 8'h00;
      txBit   <= 3'h0;
      txPar   <= 1'b0;
      txStop  <= 1'b0;
      txd     <= 1'b1;
    end else begin
      unique case (txState)
        TX_IDLE: begin
          txd <= 1'b1;
          if (txLoad) begin
            txShift <= frameMode[FM_CHR7] ? {1'b0, txHold[6:0]} : txHold;
            txPar   <= frameMode[FM_ODD];
            txBit   <= 3'h0;
            if (syncMode) begin
              txd     <= txHold[0];
              txState <= TX_DATA;
            end else begin
              txd     <= 1'b0;
              txState <= TX_START;
            end
          end
        end
        TX_START: begin
          if (txStep) begin
            txd     <= txShift[0];
            txState <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (txStep) begin
            txPar   <= txPar ^ txShift[0];
            txShift <= {1'b0, txShift[7:1]};
            txBit   <= txBit + 3'h1;
            if (txBit != lastBit) begin
              txd <= txShift[1];
            end else if (syncMode) begin
              txd     <= 1'b1;
              txState <= TX_IDLE;
            end else if (frameMode[FM_PAREN]) begin
              txd     <= txPar ^ txShift[0];
              txState <= TX_PAR;
            end else if (frameMode[FM_MPROC]) begin
              txd     <= 1'b0;
              txState <= TX_PAR;
            end else begin
              txd     <= 1'b1;
              txStop  <= frameMode[FM_STOP2];
              txState <= TX_STOP;
            end
          end
        end
        TX_PAR: begin
          if (txStep) begin
            txd     <= 1'b1;
            txStop  <= frameMode[FM_STOP2];
            txState <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (txStep) begin
            if (txStop) begin
              txStop <= 1'b0;
            end else begin
              txState <= TX_IDLE;
            end
          end
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end
  assign txDone = txStep & (((txState == TX_STOP) & ~txStop)
                | ((txState == TX_DATA) & syncMode & (txBit == lastBit)));

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  scm_rx_t    rxState;
  logic [7:0] rxShift;
  logic [2:0] rxBit;
  logic [3:0] rxPhase;
  logic       rxPar;
  logic       rxMid;
  logic       rxDone;
  logic       rxParErr;
  logic       rxFrmErr;

  assign rxMid = syncMode ? syncSample : (asyncTick & (rxPhase == 4'h7));
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxPhase <= 4'h0;
    end else if (rxState == RX_IDLE) begin
      rxPhase <= 4'h0;
    end else if (asyncTick) begin
      rxPhase <= rxPhase + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxState  <= RX_IDLE;
      rxShift  <= 8'h00;
      rxBit    <= 3'h0;
      rxPar    <= 1'b0;
      rxData   <= 8'h00;
      rxDone   <= 1'b0;
      rxParErr <= 1'b0;
      rxFrmErr <= 1'b0;
    end else begin
      rxDone   <= 1'b0;
      rxParErr <= 1'b0;
      rxFrmErr <= 1'b0;
      unique case (rxState)
        RX_IDLE: begin
          rxBit <= 3'h0;
          rxPar <= frameMode[FM_ODD];
          if (chanCtrl[CC_RXEN]) begin
            if (syncMode) begin
              rxState <= RX_DATA;
            end else if (!rxd && asyncTick) begin
              rxState <= RX_START;
            end
          end
        end
        RX_START: begin
          if (rxMid) begin
            rxState <= rxd ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rxMid) begin
            rxShift <= {rxd, rxShift[7:1]};
            rxPar   <= rxPar ^ rxd;
            rxBit   <= rxBit + 3'h1;
            if (rxBit == lastBit) begin
              if (syncMode || (!frameMode[FM_PAREN] && !frameMode[FM_MPROC])) begin
                rxState <= syncMode ? RX_IDLE : RX_STOP;
                rxData  <= frameMode[FM_CHR7] ? {1'b0, rxd, rxShift[7:2]}
                                              : {rxd, rxShift[7:1]};
                rxDone  <= syncMode;
              end else begin
                rxState <= RX_PAR;
              end
            end
          end
        end
        RX_PAR: begin
          if (rxMid) begin
            rxParErr <= frameMode[FM_PAREN] & (rxPar ^ rxd);
            rxData   <= frameMode[FM_CHR7] ? {1'b0, rxShift[7:1]} : rxShift;
            rxState  <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rxMid) begin
            if (rxState == RX_STOP && !frameMode[FM_PAREN] && !frameMode[FM_MPROC]) begin
              rxData <= frameMode[FM_CHR7] ? {1'b0, rxShift[7:1]} : rxShift;
            end
            rxFrmErr <= ~rxd;
            rxDone   <= 1'b1;
            rxState  <= RX_IDLE;
          end
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  logic [7:0] evt;
  logic       statusRead;

  assign evt = {3'b000, rxFrmErr, rxParErr, rxDone, txDone,
                chanCtrl[CC_TXIE] & ~txHoldFull};
  assign statusRead = rdStb & (wb_adr_i == IDX_IRQ_STATUS);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irqStatus <= 8'h00;
    end else if (statusRead) begin
      irqStatus <= evt;
    end else begin
      irqStatus <= irqStatus | evt;
    end
  end
  assign irq = |(irqStatus & irqMask);

endmodule

// File: core/scm_pkg.sv
package scm_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_FRAME_MODE = 16'hff78;
  localparam logic [15:0] ADDR_BIT_RATE   = 16'hff79;
  localparam logic [15:0] IDX_CHAN_CTRL   = 16'hff7a;
  localparam logic [15:0] IDX_TX_DATA     = 16'hff7b;
  localparam logic [15:0] IDX_IRQ_STATUS  = 16'hff7c;
  localparam logic [15:0] IDX_IRQ_MASK    = 16'hff7d;
  localparam logic [15:0] IDX_RX_DATA     = 16'hff7e;
  localparam logic [7:0]  RST_FRAME_MODE  = 8'h00;
  localparam logic [7:0]  RST_BIT_RATE    = 8'hff;
  localparam logic [7:0]  RST_CHAN_CTRL   = 8'h00;
  localparam logic [7:0]  RST_MASK        = 8'h00;
  // ---------------------------------------------------------------
  // Frame mode fields
  // ---------------------------------------------------------------
  localparam int FM_SYNC   = 7;
  localparam int FM_CHR7   = 6;
  localparam int FM_PAREN  = 5;
  localparam int FM_ODD    = 4;
  localparam int FM_STOP2  = 3;
  localparam int FM_MPROC  = 2;
  localparam int FM_PSC_HI = 1;
  localparam int FM_PSC_LO = 0;
  // ---------------------------------------------------------------
  // Channel control fields
  // ---------------------------------------------------------------
  localparam int CC_TXIE   = 7;
  localparam int CC_RXIE   = 6;
  localparam int CC_TXEN   = 5;
  localparam int CC_RXEN   = 4;
  localparam int CC_CKE_HI = 1;
  localparam int CC_CKE_LO = 0;
  // ---------------------------------------------------------------
  // Interrupt status fields
  // ---------------------------------------------------------------
  localparam int IS_TXEMPTY = 0;
  localparam int IS_TXEND   = 1;
  localparam int IS_RXFULL  = 2;
  localparam int IS_PARERR  = 3;
  localparam int IS_FRMERR  = 4;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SAMPLES_PER_BIT = 16;
  localparam logic [5:0] PSC_DIV4  = 6'h03;
  localparam logic [5:0] PSC_DIV16 = 6'h0f;
  localparam logic [5:0] PSC_DIV64 = 6'h3f;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} scm_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} scm_rx_t;
endpackage

// File: verif/scm_channel_chk.sv
`timescale 1ns/100ps
module scm_channel_chk
  import scm_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic [15:0] wb_adr_i,
  input wire logic [7:0]  wb_dat_i,
  input wire logic [7:0]  wb_dat_o,
  input wire logic        wb_we_i,
  input wire logic        wb_sel_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        txd,
  input wire logic        sck_oe,
  input wire logic        irq
);
  logic [7:0] frameMode;
  logic [7:0] bitRate;
  logic [7:0] chanCtrl;
  logic [7:0] irqMask;
  logic       req;
  logic       oeExp;
  logic       fastCfg;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign oeExp = !chanCtrl[CC_CKE_HI] && (frameMode[FM_SYNC] || chanCtrl[CC_CKE_LO]);
  assign fastCfg = !frameMode[FM_SYNC] && frameMode[1:0] == 2'b00 && bitRate == 8'h00;
  // ------------------------------------------------------------
  // Shadow copies of the written registers except the transmit data register.
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      frameMode <= RST_FRAME_MODE;
      bitRate   <= RST_BIT_RATE;
      chanCtrl  <= RST_CHAN_CTRL;
      irqMask   <= RST_MASK;
    end else if (req && wb_we_i && wb_sel_i) begin
      case (wb_adr_i)
        ADDR_FRAME_MODE: frameMode <= wb_dat_i;
        ADDR_BIT_RATE:   bitRate <= wb_dat_i;
        IDX_CHAN_CTRL:   chanCtrl <= wb_dat_i;
        IDX_IRQ_MASK:    irqMask <= wb_dat_i;
        default:         ;
      endcase
    end
  end
  // ------------------------------------------------------------
  // Properties.
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  sequence lowEight;
    (!txd) [*8];
  endsequence
  ack_after_req_a: assert property (req |=> wb_ack_o)
    else $error("ack missing after request");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_needs_req_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  unmapped_read_a: assert property (req && !wb_we_i
    && (wb_adr_i < ADDR_FRAME_MODE || wb_adr_i > IDX_RX_DATA) |=> wb_dat_o == 8'h00)
    else $error("unmapped read not zero");
  read_data_hold_a: assert property (!(wb_ack_o && !wb_we_i) |-> $stable(wb_dat_o))
    else $error("read data changed without read");
  clock_pin_drive_a: assert property (sck_oe == oeExp)
    else $error("clock pin drive wrong");
  masked_irq_low_a: assert property (irqMask == 8'h00 |-> !irq)
    else $error("irq with all masked");
  start_bit_len_a: assert property ($fell(txd) && fastCfg |-> lowEight ##1 lowEight)
    else $error("start bit too short");
endmodule
bind scm_channel scm_channel_chk u_chk (.ref_clk(ref_clk), .rstn(rstn), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .txd(txd),
  .sck_oe(sck_oe), .irq(irq));

// File: verif/scm_peer_model.sv
`timescale 1ns/100ps
module scm_peer_model (
  input  wire logic ref_clk,
  input  wire logic txd,
  output logic      rxd,
  output logic      sckIn
);
  localparam int BIT_CYC = 16;
  initial begin
    rxd = 1'b1;
    sckIn = 1'b1;
  end
  // Samples n bits of a frame at mid bit, start bit first.
  task automatic capture(input int n, output logic [15:0] bits);
    bits = 16'h0000;
    do @(posedge ref_clk); while (txd !== 1'b0);
    repeat (BIT_CYC / 2 - 1) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd;
      repeat (BIT_CYC) @(posedge ref_clk);
    end
  endtask
  // Counts the cycles of the first low stretch on txd.
  task automatic measureLow(output int c);
    c = 0;
    do @(posedge ref_clk); while (txd !== 1'b0);
    while (txd === 1'b0) begin
      c++;
      @(posedge ref_clk);
    end
  endtask
  // Toggles the clock pin every cycle, one rising edge per two cycles.
  task automatic clockOut(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      sckIn <= ~sckIn;
    end
  endtask
  // Sends a frame on rxd and returns the line to idle high.
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (BIT_CYC) @(posedge ref_clk);
    end
    rxd <= 1'b1;
  endtask
endmodule

// File: verif/tb_scm_channel.sv
`timescale 1ns/100ps
module tb_scm_channel;
  import scm_pkg::*;
  logic        ref_clk;
  logic        rstn;
  logic [15:0] adr;
  logic [7:0]  datW;
  logic [7:0]  datR;
  logic        we;
  logic        cyc;
  logic        sel;
  logic        ack;
  logic        txd;
  logic        rxd;
  logic        sckI;
  logic        sckOe;
  logic        irq;
  logic [7:0]  rd;
  logic [15:0] bits;
  int          n;
  int          lowLen;
  int          nMismatch;
  int          nChecks;
  int          cycles;
  int          divTab[4] = '{1, 4, 16, 64};
  logic [7:0]  fmTab[4] = '{8'h00, 8'h60, 8'h38, 8'h04};
  logic [7:0]  txTab[4] = '{8'ha5, 8'hd3, 8'h3c, 8'h96};
  scm_channel u_dut (.ref_clk(ref_clk), .rstn(rstn), .wb_adr_i(adr), .wb_dat_i(datW),
    .wb_dat_o(datR), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_ack_o(ack), .txd(txd), .rxd(rxd), .sck_i(sckI), .sck_o(), .sck_oe(sckOe), .irq(irq));
  scm_peer_model u_peer (.ref_clk(ref_clk), .txd(txd), .rxd(rxd), .sckIn(sckI));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // Tasks.
  // ------------------------------------------------------------
  task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    sel <= 1'b1;
    adr <= a;
    we <= w;
    datW <= d;
    do @(posedge ref_clk); while (ack !== 1'b1);
    rd = datR;
    cyc <= 1'b0;
    sel <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic readCheck(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    checkVal({8'h00, rd & m}, {8'h00, e});
  endtask
  function automatic logic [15:0] frameBits(input logic [7:0] fm, input logic [7:0] d);
    logic [7:0] v;
    frameBits = 16'h0000;
    v = fm[FM_CHR7] ? (d & 8'h7f) : d;
    n = 1;
    for (int i = 0; i < (fm[FM_CHR7] ? 7 : 8); i++) begin
      frameBits[n] = v[i];
      n++;
    end
    if (fm[FM_PAREN]) begin
      frameBits[n] = (^v) ^ fm[FM_ODD];
      n++;
    end else if (fm[FM_MPROC]) begin
      frameBits[n] = 1'b0;
      n++;
    end
    frameBits[n] = 1'b1;
    n = n + (fm[FM_STOP2] ? 2 : 1);
    frameBits[n - 1] = 1'b1;
  endfunction
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      nMismatch++;
      summarize();
    end
  end
  // ------------------------------------------------------------
  // Tests.
  // ------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    adr = 16'h0000;
    datW = 8'h00;
    we = 1'b0;
    cyc = 1'b0;
    nMismatch = 0;
    nChecks = 0;
    sel = 1'b0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    readCheck(ADDR_FRAME_MODE, 8'hff, RST_FRAME_MODE);
    readCheck(ADDR_BIT_RATE, 8'hff, RST_BIT_RATE);
    readCheck(IDX_CHAN_CTRL, 8'hff, RST_CHAN_CTRL);
    readCheck(IDX_IRQ_MASK, 8'hff, RST_MASK);
    wr(16'hff7f, 8'h5a);
    readCheck(16'hff7f, 8'hff, 8'h00);
    wr(ADDR_BIT_RATE, 8'h3c);
    readCheck(ADDR_BIT_RATE, 8'hff, 8'h3c);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_FRAME_MODE, {i[2], 7'h00});
      wr(IDX_CHAN_CTRL, {6'h00, i[1:0]});
      @(posedge ref_clk);
      checkVal({15'h0000, sckOe}, {15'h0000, i == 1 || i == 4 || i == 5});
    end
    $display("test clock pin done");
    wr(ADDR_BIT_RATE, 8'h01);
    wr(IDX_CHAN_CTRL, 8'h20);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_FRAME_MODE, c[7:0]);
      fork
        u_peer.measureLow(lowLen);
        wr(IDX_TX_DATA, 8'hff);
      join
      checkVal(lowLen[15:0], 16'(32 * divTab[c]));
      repeat (320 * divTab[c]) @(posedge ref_clk);
    end
    $display("test prescaler done");
    wr(ADDR_BIT_RATE, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_FRAME_MODE, fmTab[k]);
      bits = frameBits(fmTab[k], txTab[k]);
      fork
        u_peer.capture(n, bits);
        wr(IDX_TX_DATA, txTab[k]);
      join
      checkVal(bits, frameBits(fmTab[k], txTab[k]));
    end
    $display("test transmit frames done");
    wr(IDX_CHAN_CTRL, 8'h22);
    fork
      u_peer.clockOut(800);
      u_peer.measureLow(lowLen);
      wr(IDX_TX_DATA, 8'hff);
    join
    checkVal(lowLen[15:0], 16'h0020);
    $display("test external clock done");
    wr(IDX_CHAN_CTRL, 8'h10);
    readCheck(IDX_IRQ_STATUS, 8'h01, 8'h00);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_FRAME_MODE, k == 2 ? 8'h30 : 8'h20);
      bits = frameBits(k == 2 ? 8'h30 : 8'h20, 8'h5a);
      bits[9] = bits[9] ^ (k == 1);
      u_peer.send(bits, n);
      repeat (16) @(posedge ref_clk);
      readCheck(IDX_RX_DATA, 8'hff, 8'h5a);
      readCheck(IDX_IRQ_STATUS, 8'h0c, k == 1 ? 8'h0c : 8'h04);
    end
    $display("test receive done");
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_CHAN_CTRL, 8'h80);
    repeat (4) @(posedge ref_clk);
    checkVal({15'h0000, irq}, 16'h0001);
    readCheck(IDX_IRQ_STATUS, 8'h01, 8'h01);
    wr(IDX_IRQ_MASK, 8'h00);
    @(posedge ref_clk);
    checkVal({15'h0000, irq}, 16'h0000);
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_CHAN_CTRL, 8'h00);
    readCheck(IDX_IRQ_STATUS, 8'h01, 8'h01);
    repeat (4) @(posedge ref_clk);
    checkVal({15'h0000, irq}, 16'h0000);
    readCheck(IDX_IRQ_STATUS, 8'h01, 8'h00);
    $display("test interrupt done");
    summarize();
  end
endmodule
